// file: verification/bridge_window_upper_config_regs_props.sv
// Purpose: temporal checks on the upper window register block
// Assumes: only the top ports are visible; one clock domain
// Notes: read results are judged in the cycle after the read strobe
`timescale 1ns/1ps
module bridge_window_upper_props (
    input logic clk_sys_i,
    input logic rst_n_i,
    input logic [7:0] addr_i,
    input logic [31:0] wr_data_i,
    input logic wr_en_i,
    input logic rd_en_i,
    input logic [31:0] rd_data_o,
    input logic prefetch_wide_capability_i,
    input logic [11:0] prefetch_window_base_i,
    input logic io_wide_capability_i,
    input logic cfg_write_unlock_i,
    input logic fwd_valid_i,
    input logic [63:0] fwd_addr_i,
    input logic fwd_hit_o,
    input logic fwd_hit_valid_o,
    input logic [15:0] io_window_base_high_o,
    input logic [15:0] io_window_limit_high_o,
    input logic [7:0] capability_list_head_o,
    input logic prefetch_addr_64_o
);
    // ----------------------------------------------------------------
    // Helper logic
    // ----------------------------------------------------------------
    // Expressions cannot go into $past, so the unlocked write is staged
    logic cap_wr_ok_r;
    always_ff @(posedge clk_sys_i)
    begin
        cap_wr_ok_r <= wr_en_i && cfg_write_unlock_i && addr_i == 8'h34;
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_rom_reads_zero: assert property (
        $past(rst_n_i) && $past(rd_en_i) && $past(addr_i) == 8'h38
        |-> rd_data_o == 32'h0)
        else $error("option rom base read non-zero");
    a_limit_cap_mirror: assert property (
        $past(rst_n_i) && $past(rd_en_i) && $past(addr_i) == 8'h26
        |-> rd_data_o[0] == $past(prefetch_wide_capability_i)
            && rd_data_o[3:1] == 3'h0 && rd_data_o[31:16] == 16'h0)
        else $error("limit capability bit does not mirror base");
    a_pref_high_hidden: assert property (
        $past(rst_n_i) && $past(rd_en_i) && !$past(prefetch_wide_capability_i)
        && ($past(addr_i) == 8'h28 || $past(addr_i) == 8'h2C)
        |-> rd_data_o == 32'h0)
        else $error("upper prefetch half visible in 32-bit mode");
    a_io_high_hidden: assert property (
        $past(rst_n_i) && $past(rd_en_i) && !$past(io_wide_capability_i)
        && ($past(addr_i) == 8'h30 || $past(addr_i) == 8'h32)
        |-> rd_data_o == 32'h0)
        else $error("upper io half visible without io capability");
    a_hit_valid_delay: assert property (
        $past(rst_n_i) |-> fwd_hit_valid_o == $past(fwd_valid_i))
        else $error("lookup answer not one cycle after request");
    a_hit_qualified: assert property (
        fwd_hit_o |-> fwd_hit_valid_o)
        else $error("window hit without a lookup answer");
    a_cap_ptr_locked: assert property (
        $past(rst_n_i) && !$stable(capability_list_head_o) |-> cap_wr_ok_r)
        else $error("capability pointer changed without unlocked write");
    a_mode_follows_cap: assert property (
        $past(rst_n_i)
        |-> prefetch_addr_64_o == $past(prefetch_wide_capability_i))
        else $error("addressing mode does not follow capability bit");
endmodule

bind bridge_window_upper_config_regs bridge_window_upper_props
    i_bridge_window_upper_props (.clk_sys_i, .rst_n_i, .addr_i,
    .wr_data_i, .wr_en_i, .rd_en_i, .rd_data_o, .prefetch_wide_capability_i,
    .prefetch_window_base_i, .io_wide_capability_i, .cfg_write_unlock_i,
    .fwd_valid_i, .fwd_addr_i, .fwd_hit_o, .fwd_hit_valid_o,
    .io_window_base_high_o, .io_window_limit_high_o, .capability_list_head_o,
    .prefetch_addr_64_o);

// file: verification/bridge_window_upper_config_regs_tb_top.sv
// Purpose: self-checking bench for the upper window register block
// Assumes: one register access or lookup per cycle, strobes by NBA
// Notes: expected reads and hits queue up; a negedge monitor compares
`timescale 1ns/1ps
module bridge_window_upper_config_regs_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic wr_en = 1'b0, rd_en = 1'b0, fwd_v = 1'b0;
    logic pcap = 1'b1, io_wide_capability = 1'b1, unlock = 1'b1;
    logic [11:0] pbase = 12'h345;
    logic [63:0] faddr = 64'h0;
    wire [31:0] rdat;
    wire hit, hit_v, p64;
    wire [15:0] iob, iol;
    wire [7:0] cap;
    logic [31:0] rdq [$];
    logic hitq [$];
    logic [31:0] mdl [0:63];
    logic [7:0] ofs [0:8] = '{8'h26, 8'h28, 8'h2C, 8'h30, 8'h32, 8'h34,
                              8'h38, 8'h3C, 8'h40};
    logic rd_seen = 1'b0, lk_seen = 1'b0;
    int error_cnt = 0, comparisons = 0;

    initial forever #4 clk = ~clk;

    bridge_window_upper_config_regs i_bridge_window_upper_config_regs (
        .clk_sys_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wr_data_i(wdat),
        .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rdat),
        .prefetch_wide_capability_i(pcap), .prefetch_window_base_i(pbase),
        .io_wide_capability_i(io_wide_capability), .cfg_write_unlock_i(unlock),
        .fwd_valid_i(fwd_v), .fwd_addr_i(faddr), .fwd_hit_o(hit),
        .fwd_hit_valid_o(hit_v), .io_window_base_high_o(iob),
        .io_window_limit_high_o(iol), .capability_list_head_o(cap),
        .prefetch_addr_64_o(p64));

    // ----------------------------------------------------------------
    // Reference and checking
    // ----------------------------------------------------------------
    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        case (a)
            8'h26: exp_rd = {16'h0, mdl[6'h26][15:4], 3'h0, pcap};
            8'h28, 8'h2C: exp_rd = pcap ? mdl[a[5:0]] : 32'h0;
            8'h30, 8'h32: exp_rd = io_wide_capability ? {16'h0, mdl[a[5:0]][15:0]} : 32'h0;
            8'h34, 8'h3C: exp_rd = {24'h0, mdl[a[5:0]][7:0]};
            default: exp_rd = 32'h0;
        endcase
    endfunction

    function automatic logic hit_of(input logic [63:0] x);
        logic [63:0] lo, hi;
        lo = {pcap ? mdl[6'h28] : 32'h0, pbase, 20'h0};
        hi = {pcap ? mdl[6'h2C] : 32'h0, mdl[6'h26][15:4], 20'hFFFFF};
        hit_of = x >= lo && x <= hi;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    always @(negedge clk)
    begin
        if (rd_seen)
            chk(rdat, rdq.pop_front());
        if (lk_seen)
            chk({30'h0, hit_v, hit}, {30'h1, hitq.pop_front()});
        rd_seen = rd_en;
        lk_seen = fwd_v;
    end

    // ----------------------------------------------------------------
    // Drivers, one cycle per wr, rd or lk; idle and do_reset take n cycles
    // ----------------------------------------------------------------
    task automatic drive(input logic w, input logic r, input logic f);
        wr_en <= w;
        rd_en <= r;
        fwd_v <= f;
    endtask

    task automatic idle(input int n);
        drive(1'b0, 1'b0, 1'b0);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        drive(1'b1, 1'b0, 1'b0);
        addr <= a;
        wdat <= d;
        // Stored value survives while hidden, so track only taken writes
        if (a == 8'h26 || a == 8'h3C || (a == 8'h34 && unlock)
            || (a[7:3] == 5'h05 && pcap) || (a[7:2] == 6'h0C && io_wide_capability))
            mdl[a[5:0]] = d;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a);
        drive(1'b0, 1'b1, 1'b0);
        addr <= a;
        rdq.push_back(exp_rd(a));
        @(posedge clk);
    endtask

    task automatic lk(input logic [63:0] x);
        drive(1'b0, 1'b0, 1'b1);
        faddr <= x;
        hitq.push_back(hit_of(x));
        @(posedge clk);
    endtask

    task automatic do_reset(input int n);
        rst_n <= 1'b0;
        idle(n);
        rst_n <= 1'b1;
        mdl[6'h26] = 32'h0;
        mdl[6'h28] = 32'hFFFFFFFF;
        mdl[6'h2C] = 32'h0;
        mdl[6'h30] = 32'hFFFF;
        mdl[6'h32] = 32'h0;
        mdl[6'h34] = 32'h40;
        mdl[6'h3C] = 32'h0;
    endtask

    task automatic wr_rd_all(input string nm);
        foreach (ofs[k])
        begin
            wr(ofs[k], $urandom());
            rd(ofs[k]);
        end
        $display("test %s done", nm);
    endtask

    task automatic stop_test();
        $display("comparisons=%0d errors=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h9416));
        do_reset(10);
        foreach (ofs[k]) rd(ofs[k]);
        wr_rd_all("write readback");
        idle(2);
        chk({16'h0, iob}, {16'h0, mdl[6'h30][15:0]});
        chk({16'h0, iol}, {16'h0, mdl[6'h32][15:0]});
        chk({24'h0, cap}, {24'h0, mdl[6'h34][7:0]});
        chk({31'h0, p64}, 32'h1);
        pcap <= 1'b0;
        io_wide_capability <= 1'b0;
        wr_rd_all("hidden halves");
        chk({31'h0, p64}, 32'h0);
        chk({16'h0, iob}, 32'h0);
        chk({16'h0, iol}, 32'h0);
        pcap <= 1'b1;
        io_wide_capability <= 1'b1;
        idle(1);
        foreach (ofs[k]) rd(ofs[k]);
        unlock <= 1'b0;
        idle(1);
        wr(8'h34, 32'hA5);
        rd(8'h34);
        unlock <= 1'b1;
        wr(8'h28, 32'h1);
        wr(8'h2C, 32'h1);
        wr(8'h26, 32'h9AB0);
        lk(64'h1_3450_0000);
        lk(64'h1_344F_FFFF);
        lk(64'h1_9ABF_FFFF);
        lk(64'h1_9AC0_0000);
        repeat (8) lk({31'h0, 1'($urandom_range(1)), $urandom()});
        pcap <= 1'b0;
        idle(1);
        lk(64'h0_3450_0000);
        lk(64'h1_5000_0000);
        lk(64'h0_344F_FFFF);
        pcap <= 1'b1;
        $display("test lookup done");
        do_reset(2);
        foreach (ofs[k]) rd(ofs[k]);
        $display("test second reset done");
        for (int i = 0; i < 10 && rdq.size() + hitq.size() > 0; i++)
            idle(1);
        if (rdq.size() + hitq.size() > 0)
            error_cnt++;
        stop_test();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        $display("[FAIL] t=%0t timeout", $time);
        stop_test();
    end
endmodule

// file: verilog/bridge_window_upper_config_regs.v
// Purpose: upper bridge window, capability pointer, option ROM and
//          interrupt line configuration registers
// Assumes: lower base registers, capability bits and write lock come from
//          neighbouring logic on the same clock
// Notes: read data valid only in the cycle after the read strobe
`timescale 1ns/1ps
`include "bridge_window_upper_consts.vh"
module bridge_window_upper_config_regs (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire [7:0] addr_i,
    input wire [31:0] wr_data_i,
    input wire wr_en_i,
    input wire rd_en_i,
    output wire [31:0] rd_data_o,
    input wire prefetch_wide_capability_i,
    input wire [11:0] prefetch_window_base_i,
    input wire io_wide_capability_i,
    input wire cfg_write_unlock_i,
    input wire fwd_valid_i,
    input wire [63:0] fwd_addr_i,
    output wire fwd_hit_o,
    output wire fwd_hit_valid_o,
    output wire [15:0] io_window_base_high_o,
    output wire [15:0] io_window_limit_high_o,
    output wire [7:0] capability_list_head_o,
    output wire prefetch_addr_64_o
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg [11:0] prefetch_window_limit_r;
    reg [31:0] prefetch_window_base_high_r;
    reg [31:0] prefetch_window_limit_high_r;
    reg [15:0] io_window_base_high_r;
    reg [15:0] io_window_limit_high_r;
    reg [7:0] capability_list_head_r;
    reg [7:0] interrupt_routing_line_r;
    reg [31:0] rd_data_r;
    reg [31:0] rd_data_nxt;
    reg [15:0] io_base_out_r;
    reg [15:0] io_limit_out_r;
    reg prefetch_addr_64_r;

    wire sel_pf_limit;
    wire sel_pf_base_high;
    wire sel_pf_limit_high;
    wire sel_io_base_high;
    wire sel_io_limit_high;
    wire sel_cap_head;
    wire sel_int_line;

    wire prefetch_addr_32;
    wire [31:0] pf_base_high_vis;
    wire [31:0] pf_limit_high_vis;
    wire [15:0] io_base_high_vis;
    wire [15:0] io_limit_high_vis;
    wire [15:0] pf_limit_vis;

    wire wr_pf_limit;
    wire wr_pf_base_high;
    wire wr_pf_limit_high;
    wire wr_io_base_high;
    wire wr_io_limit_high;
    wire wr_cap_head;
    wire wr_int_line;

    wire [31:0] word_pf_limit;
    wire [31:0] word_pf_base_high;
    wire [31:0] word_pf_limit_high;
    wire [31:0] word_io_base_high;
    wire [31:0] word_io_limit_high;
    wire [31:0] word_cap_head;
    wire [31:0] word_rom_base;
    wire [31:0] word_int_line;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    assign sel_pf_limit = (addr_i == `OFS_PREFETCH_WINDOW_LIMIT);
    assign sel_pf_base_high = (addr_i == `OFS_PREFETCH_WINDOW_BASE_HIGH);
    assign sel_pf_limit_high = (addr_i == `OFS_PREFETCH_WINDOW_LIMIT_HIGH);
    assign sel_io_base_high = (addr_i == `OFS_IO_WINDOW_BASE_HIGH);
    assign sel_io_limit_high = (addr_i == `OFS_IO_WINDOW_LIMIT_HIGH);
    assign sel_cap_head = (addr_i == `OFS_CAPABILITY_LIST_HEAD);
    assign sel_int_line = (addr_i == `OFS_INTERRUPT_ROUTING_LINE);

    // ----------------------------------------------------------------
    // Write enables
    // ----------------------------------------------------------------
    // Option ROM base has no write path, so its writes simply vanish
    assign wr_pf_limit = wr_en_i && sel_pf_limit;
    assign wr_pf_base_high = wr_en_i && sel_pf_base_high &&
                             prefetch_wide_capability_i;
    assign wr_pf_limit_high = wr_en_i && sel_pf_limit_high &&
                              prefetch_wide_capability_i;
    assign wr_io_base_high = wr_en_i && sel_io_base_high &&
                             io_wide_capability_i;
    assign wr_io_limit_high = wr_en_i && sel_io_limit_high &&
                              io_wide_capability_i;
    assign wr_cap_head = wr_en_i && sel_cap_head &&
                         cfg_write_unlock_i;
    assign wr_int_line = wr_en_i && sel_int_line;

    // ----------------------------------------------------------------
    // Capability qualified views
    // ----------------------------------------------------------------
    // One selects 64-bit, zero selects 32-bit prefetchable addressing
    assign prefetch_addr_32 = ~prefetch_wide_capability_i;

    // Stored value kept but hidden, so it reappears if the bit returns
    assign pf_base_high_vis = prefetch_addr_32 ? `UPPER_ZERO :
                              prefetch_window_base_high_r;
    assign pf_limit_high_vis = prefetch_addr_32 ? `UPPER_ZERO :
                               prefetch_window_limit_high_r;
    assign io_base_high_vis = io_wide_capability_i ?
                              io_window_base_high_r : 16'h0000;
    assign io_limit_high_vis = io_wide_capability_i ?
                               io_window_limit_high_r : 16'h0000;

    // Capability bit mirrored from base, reserved bits zero
    assign pf_limit_vis = {prefetch_window_limit_r, 3'h0,
                           prefetch_wide_capability_i};

    // ----------------------------------------------------------------
    // Read words, zero extended
    // ----------------------------------------------------------------
    // Unmapped offsets fall to the default word of zero
    assign word_pf_limit = {16'h0000, pf_limit_vis};
    assign word_pf_base_high = pf_base_high_vis;
    assign word_pf_limit_high = pf_limit_high_vis;
    assign word_io_base_high = {16'h0000, io_base_high_vis};
    assign word_io_limit_high = {16'h0000, io_limit_high_vis};
    assign word_cap_head = {24'h000000, capability_list_head_r};
    assign word_rom_base = `OPTION_ROM_BASE_VALUE;
    assign word_int_line = {24'h000000, interrupt_routing_line_r};

    // ----------------------------------------------------------------
    // Prefetchable limit, bits 15:4 only
    // ----------------------------------------------------------------
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            prefetch_window_limit_r <= `RST_PREFETCH_WINDOW_LIMIT;
        end
        else if (wr_pf_limit)
        begin
            prefetch_window_limit_r <=
                wr_data_i[`LIMIT_ADDR_MSB:`LIMIT_ADDR_LSB];
        end
    end

    // ----------------------------------------------------------------
    // Prefetchable upper halves
    // ----------------------------------------------------------------
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            prefetch_window_base_high_r <= `RST_PREFETCH_WINDOW_BASE_HIGH;
        end
        else if (wr_pf_base_high)
        begin
            prefetch_window_base_high_r <= wr_data_i;
        end
    end

    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            prefetch_window_limit_high_r <= `RST_PREFETCH_WINDOW_LIMIT_HIGH;
        end
        else if (wr_pf_limit_high)
        begin
            prefetch_window_limit_high_r <= wr_data_i;
        end
    end

    // ----------------------------------------------------------------
    // I/O upper halves
    // ----------------------------------------------------------------
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            io_window_base_high_r <= `RST_IO_WINDOW_BASE_HIGH;
        end
        else if (wr_io_base_high)
        begin
            io_window_base_high_r <= wr_data_i[15:0];
        end
    end

    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            io_window_limit_high_r <= `RST_IO_WINDOW_LIMIT_HIGH;
        end
        else if (wr_io_limit_high)
        begin
            io_window_limit_high_r <= wr_data_i[15:0];
        end
    end

    // ----------------------------------------------------------------
    // Capability pointer, locked write
    // ----------------------------------------------------------------
    // Locked writes are dropped silently; the bus never sees an error
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            capability_list_head_r <= `RST_CAPABILITY_LIST_HEAD;
        end
        else if (wr_cap_head)
        begin
            capability_list_head_r <= wr_data_i[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Interrupt line, storage only
    // ----------------------------------------------------------------
    // Read back only; feeds no interrupt or routing logic here
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            interrupt_routing_line_r <= `RST_INTERRUPT_ROUTING_LINE;
        end
        else if (wr_int_line)
        begin
            interrupt_routing_line_r <= wr_data_i[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Read multiplexer
    // ----------------------------------------------------------------
    always @*
    begin
        rd_data_nxt = 32'h00000000;
        if (rd_en_i)
        begin
            case (addr_i)
                `OFS_PREFETCH_WINDOW_LIMIT:
                begin
                    rd_data_nxt = word_pf_limit;
                end
                `OFS_PREFETCH_WINDOW_BASE_HIGH:
                begin
                    rd_data_nxt = word_pf_base_high;
                end
                `OFS_PREFETCH_WINDOW_LIMIT_HIGH:
                begin
                    rd_data_nxt = word_pf_limit_high;
                end
                `OFS_IO_WINDOW_BASE_HIGH:
                begin
                    rd_data_nxt = word_io_base_high;
                end
                `OFS_IO_WINDOW_LIMIT_HIGH:
                begin
                    rd_data_nxt = word_io_limit_high;
                end
                `OFS_CAPABILITY_LIST_HEAD:
                begin
                    rd_data_nxt = word_cap_head;
                end
                `OFS_OPTION_ROM_BASE:
                begin
                    rd_data_nxt = word_rom_base;
                end
                `OFS_INTERRUPT_ROUTING_LINE:
                begin
                    rd_data_nxt = word_int_line;
                end
                default:
                begin
                    rd_data_nxt = 32'h00000000;
                end
            endcase
        end
    end

    // Cleared when idle so data stand only in the cycle after the read
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            rd_data_r <= 32'h00000000;
        end
        else
        begin
            rd_data_r <= rd_data_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Window outputs toward forwarding logic
    // ----------------------------------------------------------------
    // One cycle late against the registers; forwarding tolerates this
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            io_base_out_r <= 16'h0000;
            io_limit_out_r <= 16'h0000;
            prefetch_addr_64_r <= 1'b0;
        end
        else
        begin
            io_base_out_r <= io_base_high_vis;
            io_limit_out_r <= io_limit_high_vis;
            prefetch_addr_64_r <= prefetch_wide_capability_i;
        end
    end

    // ----------------------------------------------------------------
    // Prefetchable window decision
    // ----------------------------------------------------------------
    prefetch_window_match i_prefetch_window_match (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .wide_i(prefetch_wide_capability_i),
        .base_high_i(pf_base_high_vis),
        .base_low_i(prefetch_window_base_i),
        .limit_high_i(pf_limit_high_vis),
        .limit_low_i(prefetch_window_limit_r),
        .req_valid_i(fwd_valid_i),
        .req_addr_i(fwd_addr_i),
        .hit_o(fwd_hit_o),
        .hit_valid_o(fwd_hit_valid_o)
    );

    assign rd_data_o = rd_data_r;
    assign io_window_base_high_o = io_base_out_r;
    assign io_window_limit_high_o = io_limit_out_r;
    assign capability_list_head_o = capability_list_head_r;
    assign prefetch_addr_64_o = prefetch_addr_64_r;
endmodule

// file: verilog/bridge_window_upper_consts.vh
// Purpose: constants for the upper bridge window configuration registers
// Assumes: byte offsets on an 8-bit configuration address, 32-bit data
// Notes: every register offset, limit field position and configuration register reset value lives here
`ifndef BRIDGE_WINDOW_UPPER_CONSTS_VH
`define BRIDGE_WINDOW_UPPER_CONSTS_VH

// --------------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------------
`define OFS_PREFETCH_WINDOW_LIMIT 8'h26
`define OFS_PREFETCH_WINDOW_BASE_HIGH 8'h28
`define OFS_PREFETCH_WINDOW_LIMIT_HIGH 8'h2C
`define OFS_IO_WINDOW_BASE_HIGH 8'h30
`define OFS_IO_WINDOW_LIMIT_HIGH 8'h32
`define OFS_CAPABILITY_LIST_HEAD 8'h34
`define OFS_OPTION_ROM_BASE 8'h38
`define OFS_INTERRUPT_ROUTING_LINE 8'h3C

// --------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------
`define LIMIT_CAP_BIT 0
`define LIMIT_ADDR_MSB 15
`define LIMIT_ADDR_LSB 4

// --------------------------------------------------------------------
// Reset values
// --------------------------------------------------------------------
`define RST_PREFETCH_WINDOW_LIMIT 12'h000
`define RST_PREFETCH_WINDOW_BASE_HIGH 32'hFFFFFFFF
`define RST_PREFETCH_WINDOW_LIMIT_HIGH 32'h00000000
`define RST_IO_WINDOW_BASE_HIGH 16'hFFFF
`define RST_IO_WINDOW_LIMIT_HIGH 16'h0000
`define RST_CAPABILITY_LIST_HEAD 8'h40
`define RST_INTERRUPT_ROUTING_LINE 8'h00
`define OPTION_ROM_BASE_VALUE 32'h00000000

// --------------------------------------------------------------------
// Window address fill
// --------------------------------------------------------------------
`define WINDOW_BASE_FILL 20'h00000
`define WINDOW_LIMIT_FILL 20'hFFFFF
`define UPPER_ZERO 32'h00000000

`endif

// file: verilog/prefetch_window_match.v
// Purpose: registered prefetchable window hit decision
// Assumes: request address and window fields stable in the request cycle
// Notes: answer appears one clock after the request
`timescale 1ns/1ps
`include "bridge_window_upper_consts.vh"
module prefetch_window_match (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire wide_i,
    input wire [31:0] base_high_i,
    input wire [11:0] base_low_i,
    input wire [31:0] limit_high_i,
    input wire [11:0] limit_low_i,
    input wire req_valid_i,
    input wire [63:0] req_addr_i,
    output wire hit_o,
    output wire hit_valid_o
);
    wire [31:0] base_top;
    wire [31:0] limit_top;
    wire [63:0] base_full;
    wire [63:0] limit_full;
    wire in_window;
    reg hit_r;
    reg hit_valid_r;

    // ----------------------------------------------------------------
    // Combined window bounds
    // ----------------------------------------------------------------
    // Upper halves ignored in 32-bit mode, so windows stay below 4 GB
    assign base_top = wide_i ? base_high_i : `UPPER_ZERO;
    assign limit_top = wide_i ? limit_high_i : `UPPER_ZERO;
    assign base_full = {base_top, base_low_i, `WINDOW_BASE_FILL};
    assign limit_full = {limit_top, limit_low_i, `WINDOW_LIMIT_FILL};
    assign in_window = (req_addr_i >= base_full) &&
                       (req_addr_i <= limit_full);

    // ----------------------------------------------------------------
    // Registered answer
    // ----------------------------------------------------------------
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            hit_r <= 1'b0;
            hit_valid_r <= 1'b0;
        end
        else
        begin
            hit_r <= req_valid_i && in_window;
            hit_valid_r <= req_valid_i;
        end
    end

    assign hit_o = hit_r;
    assign hit_valid_o = hit_valid_r;
endmodule
